// File: core/fesel_top.sv
// Front-end status and error logic: latched error flags, overall error, ERR pin.
// Assumes condition inputs synchronous to REF_CLK_I; host on the serial port.
`timescale 1ns/100ps
`include "fesel_cfg.svh"

module fesel_top #(
    parameter logic [7:0] REV_ID = 8'h5A // Arbitrary value
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // Serial port
    input wire logic CS_N_I,
    input wire logic SCLK_I,
    input wire logic MOSI_I,
    output logic MISO_O,
    output logic MISO_OE_O,
    // Error conditions and converter checksum enable
    input wire logic CHAN_ERR_I,
    input wire logic TEMP_SD_I,
    input wire logic TEMP_HI_I,
    input wire logic CONV_CRC_EN_I,
    // Open-drain active-low error pin
    output logic ERR_N_O,
    output logic ERR_N_OE_O,
    // Thermal shutdown and power controls
    output logic FORCE_VMODE_O,
    output logic CUR_SRC_OFF_O,
    output logic FIELD_SUPPLY_OFF_O,
    output logic AMP_PWRDN_O
);
    import fesel_pkg::*;

    logic [`FESEL_ADDR_W-1:0] addr;
    logic rd_stb, wr_stb, crc_err, crc_on;
    logic [`FESEL_DATA_W-1:0] wr_data, rd_data, status;
    fesel_flags_t flags_q, flags_d, mask_q, mask_d, events, cond;
    logic [1:0] crc_field_q, crc_field_d;
    logic cur_off_q, cur_off_d;
    logic overall_q, overall_d, tsd_q, tsd_d, rtd_off_q, rtd_off_d;
    logic clr;

    assign crc_on = (crc_field_q == `FESEL_CRC_ON_PATTERN) && CONV_CRC_EN_I;

    // Port is never gated by the shutdown state
    fesel_spi u_spi (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .cs_n_i(CS_N_I),
        .sclk_i(SCLK_I),
        .mosi_i(MOSI_I),
        .miso_o(MISO_O),
        .miso_oe_o(MISO_OE_O),
        .crc_on_i(crc_on),
        .rd_data_i(rd_data),
        .addr_o(addr),
        .rd_stb_o(rd_stb),
        .wr_stb_o(wr_stb),
        .wr_data_o(wr_data),
        .crc_err_o(crc_err)
    );

    assign events = {CHAN_ERR_I, crc_err, TEMP_SD_I, TEMP_HI_I};
    // Checksum failure has no lasting condition, so its latched flag stands in
    assign cond = {CHAN_ERR_I, flags_q[`FESEL_IDX_CRC], TEMP_SD_I, TEMP_HI_I};
    assign clr = rd_stb && (addr == `FESEL_OFF_TOP_STATUS);

    always_comb begin
        status = 16'h0000;
        status[`FESEL_REV_MSB:`FESEL_REV_LSB] = REV_ID;
        status[`FESEL_FLAG_MSB:`FESEL_FLAG_LSB] = flags_q;
        status[`FESEL_OVERALL_BIT] = overall_q;
        rd_data = 16'h0000;
        case (addr)
            `FESEL_OFF_TOP_STATUS: rd_data = status;
            `FESEL_OFF_CTRL: begin
                rd_data[`FESEL_CRC_FIELD_MSB:`FESEL_CRC_FIELD_LSB] = crc_field_q;
                rd_data[`FESEL_CUR_OFF_BIT] = cur_off_q;
            end
            `FESEL_OFF_ERR_MASK: rd_data[`FESEL_FLAG_MSB:`FESEL_FLAG_LSB] = mask_q;
            default: rd_data = 16'h0000;
        endcase
    end

    always_comb begin
        mask_d = mask_q;
        crc_field_d = crc_field_q;
        cur_off_d = cur_off_q;
        if (wr_stb && addr == `FESEL_OFF_ERR_MASK) begin
            mask_d = wr_data[`FESEL_FLAG_MSB:`FESEL_FLAG_LSB];
        end
        if (wr_stb && addr == `FESEL_OFF_CTRL) begin
            crc_field_d = wr_data[`FESEL_CRC_FIELD_MSB:`FESEL_CRC_FIELD_LSB];
            cur_off_d = wr_data[`FESEL_CUR_OFF_BIT];
        end
        // Set wins over the clearing read
        flags_d = (clr ? `FESEL_FLAGS_RESET : flags_q) | events;
        overall_d = |(cond & ~mask_q);
        tsd_d = flags_d[`FESEL_IDX_TSD];
        rtd_off_d = cur_off_d | flags_d[`FESEL_IDX_TSD];
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            mask_q <= `FESEL_MASK_RESET;
            crc_field_q <= 2'h0;
            cur_off_q <= 1'b0;
            flags_q <= `FESEL_FLAGS_RESET;
            overall_q <= 1'b0;
            tsd_q <= 1'b0;
            rtd_off_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            crc_field_q <= crc_field_d;
            cur_off_q <= cur_off_d;
            flags_q <= flags_d;
            overall_q <= overall_d;
            tsd_q <= tsd_d;
            rtd_off_q <= rtd_off_d;
        end
    end

    // Pin level is always low; only the enable moves
    assign ERR_N_O = 1'b0;
    assign ERR_N_OE_O = overall_q;
    assign FORCE_VMODE_O = tsd_q;
    assign CUR_SRC_OFF_O = rtd_off_q;
    assign FIELD_SUPPLY_OFF_O = tsd_q;
    assign AMP_PWRDN_O = tsd_q;

    property p_flag_latch;
        @(posedge REF_CLK_I) disable iff (RST_I)
        TEMP_HI_I ##1 (!TEMP_HI_I && !clr) |-> status[2];
    endproperty
    a_flag_latch: assert property (p_flag_latch) else $error("overtemp flag lost");

    property p_overall;
        @(posedge REF_CLK_I) disable iff (RST_I)
        1'b1 |=> overall_q == $past(|(cond & ~mask_q));
    endproperty
    a_overall: assert property (p_overall) else $error("overall bit wrong");

    property p_read_keeps;
        @(posedge REF_CLK_I) disable iff (RST_I)
        clr && TEMP_SD_I && !mask_q[`FESEL_IDX_TSD] |=> overall_q;
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read cleared overall");

    property p_mask_all;
        @(posedge REF_CLK_I) disable iff (RST_I)
        mask_q == 4'hF |=> !overall_q;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("masked error drives overall");

    property p_chan_clear;
        @(posedge REF_CLK_I) disable iff (RST_I)
        clr && !CHAN_ERR_I |=> !status[5];
    endproperty
    a_chan_clear: assert property (p_chan_clear) else $error("channel flag not cleared");

    property p_crc_flag;
        @(posedge REF_CLK_I) disable iff (RST_I)
        crc_err |=> status[4] && !$past(wr_stb);
    endproperty
    a_crc_flag: assert property (p_crc_flag) else $error("checksum flag missing");

    property p_tsd_actions;
        @(posedge REF_CLK_I) disable iff (RST_I)
        TEMP_SD_I |=> FORCE_VMODE_O && CUR_SRC_OFF_O && FIELD_SUPPLY_OFF_O && AMP_PWRDN_O;
    endproperty
    a_tsd_actions: assert property (p_tsd_actions) else $error("shutdown action missing");

    property p_err_pin;
        @(posedge REF_CLK_I) disable iff (RST_I)
        (|(cond & ~mask_q)) |=> ERR_N_OE_O && !ERR_N_O;
    endproperty
    a_err_pin: assert property (p_err_pin) else $error("error pin not driven");

    property p_set_wins;
        @(posedge REF_CLK_I) disable iff (RST_I)
        clr |=> (flags_q & $past(events)) == $past(events);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost on read");

    c_clear_read: cover property (@(posedge REF_CLK_I) disable iff (RST_I) clr && |flags_q);
    c_crc_fail: cover property (@(posedge REF_CLK_I) disable iff (RST_I) crc_err);
    c_shutdown: cover property (@(posedge REF_CLK_I) disable iff (RST_I) tsd_q && wr_stb);
endmodule

// File: core/fesel_cfg.svh
// Offsets, field positions, reset values and patterns of the status block.
// Assumes inclusion by bare name from the core files only.
`ifndef FESEL_CFG_SVH
`define FESEL_CFG_SVH

`define FESEL_ADDR_W 4
`define FESEL_DATA_W 16
`define FESEL_CMD_BITS 8
`define FESEL_CRC_BITS 8
`define FESEL_CRC_POLY 8'h07
`define FESEL_CMD_RD_BIT 6

`define FESEL_OFF_TOP_STATUS 4'h0
`define FESEL_OFF_CTRL 4'h1
`define FESEL_OFF_ERR_MASK 4'h6

`define FESEL_REV_MSB 15
`define FESEL_REV_LSB 8
`define FESEL_FLAG_MSB 5
`define FESEL_FLAG_LSB 2
`define FESEL_OVERALL_BIT 0
`define FESEL_CRC_FIELD_MSB 14
`define FESEL_CRC_FIELD_LSB 13
`define FESEL_CRC_ON_PATTERN 2'h2
`define FESEL_CUR_OFF_BIT 9

`define FESEL_CTRL_RESET 16'h0000
`define FESEL_MASK_RESET 4'h0
`define FESEL_FLAGS_RESET 4'h0

// Index of each flag within the four-bit flag vector
`define FESEL_IDX_CHAN 3
`define FESEL_IDX_CRC 2
`define FESEL_IDX_TSD 1
`define FESEL_IDX_THI 0

`endif

// File: core/fesel_pkg.sv
// Types shared by the status block and its serial port.
// Assumes nothing of its surroundings.
package fesel_pkg;
    typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_CRC, PH_DONE} fesel_phase_t;
    typedef logic [3:0] fesel_flags_t;
endpackage

// File: core/fesel_spi.sv
// Four-wire serial register port: command byte, 16 data bits, optional CRC byte.
// Assumes pins synchronous to the clock and SCLK well below half its rate.
`timescale 1ns/100ps
`include "fesel_cfg.svh"

module fesel_spi (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Serial pins, clock idles high
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    // Register side
    input wire logic crc_on_i,
    input wire logic [`FESEL_DATA_W-1:0] rd_data_i,
    output logic [`FESEL_ADDR_W-1:0] addr_o,
    output logic rd_stb_o,
    output logic wr_stb_o,
    output logic [`FESEL_DATA_W-1:0] wr_data_o,
    output logic crc_err_o
);
    import fesel_pkg::*;

    fesel_phase_t phase_q, phase_d;
    logic [4:0] cnt_q, cnt_d;
    logic [`FESEL_DATA_W-1:0] sh_q, sh_d, tx_q, tx_d, wdat_q, wdat_d;
    logic [`FESEL_CMD_BITS-1:0] cmd_q, cmd_d;
    logic [`FESEL_CRC_BITS-1:0] crc_q, crc_d;
    logic sclk_q, miso_q, miso_d, oe_q, oe_d;
    logic rd_q, rd_d, wr_q, wr_d, cerr_q, cerr_d;
    logic rise, fall, is_rd;

    assign rise = sclk_i & ~sclk_q;
    assign fall = ~sclk_i & sclk_q;
    assign is_rd = cmd_q[`FESEL_CMD_RD_BIT];

    always_comb begin
        phase_d = phase_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        wdat_d = wdat_q;
        cmd_d = cmd_q;
        crc_d = crc_q;
        miso_d = miso_q;
        oe_d = oe_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        cerr_d = 1'b0;
        if (rd_q) begin
            tx_d = rd_data_i;
        end
        if (cs_n_i) begin
            phase_d = PH_CMD;
            cnt_d = 5'h00;
            crc_d = 8'h00;
            oe_d = 1'b0;
        end else if (rise) begin
            sh_d = {sh_q[`FESEL_DATA_W-2:0], mosi_i};
            crc_d = {crc_q[6:0], 1'b0} ^ ((crc_q[7] ^ mosi_i) ? `FESEL_CRC_POLY : 8'h00);
            cnt_d = cnt_q + 5'h01;
            case (phase_q)
                PH_CMD: begin
                    if (cnt_q == 5'h07) begin
                        cmd_d = {sh_q[6:0], mosi_i};
                        phase_d = PH_DATA;
                        cnt_d = 5'h00;
                        // Command bit 7 sits in sh_q[6] here; it must be zero
                        rd_d = sh_q[`FESEL_CMD_RD_BIT - 1] & ~sh_q[`FESEL_CMD_RD_BIT];
                        oe_d = sh_q[`FESEL_CMD_RD_BIT - 1];
                    end
                end
                PH_DATA: begin
                    if (cnt_q == 5'h0F) begin
                        cnt_d = 5'h00;
                        wdat_d = {sh_q[`FESEL_DATA_W-2:0], mosi_i};
                        phase_d = PH_DONE;
                        oe_d = 1'b0;
                        if (!is_rd && crc_on_i) begin
                            phase_d = PH_CRC;
                        end else if (!is_rd) begin
                            wr_d = 1'b1;
                        end
                    end
                end
                PH_CRC: begin
                    if (cnt_q == 5'h07) begin
                        phase_d = PH_DONE;
                        wr_d = (crc_d == 8'h00);
                        cerr_d = (crc_d != 8'h00);
                    end
                end
                default: begin
                    cnt_d = cnt_q;
                end
            endcase
        end else if (fall && phase_q == PH_DATA && is_rd) begin
            miso_d = tx_q[`FESEL_DATA_W-1];
            tx_d = {tx_q[`FESEL_DATA_W-2:0], 1'b0};
        end
    end

    // Read bit is bit 6 of the command; bit 7 must be zero for a read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phase_q <= PH_CMD;
            cnt_q <= 5'h00;
            sh_q <= 16'h0000;
            tx_q <= 16'h0000;
            wdat_q <= 16'h0000;
            cmd_q <= 8'h00;
            crc_q <= 8'h00;
            sclk_q <= 1'b1;
            miso_q <= 1'b0;
            oe_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cerr_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            wdat_q <= wdat_d;
            cmd_q <= cmd_d;
            crc_q <= crc_d;
            sclk_q <= sclk_i;
            miso_q <= miso_d;
            oe_q <= oe_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            cerr_q <= cerr_d;
        end
    end

    assign miso_o = miso_q;
    assign miso_oe_o = oe_q;
    assign addr_o = cmd_q[`FESEL_ADDR_W-1:0];
    assign rd_stb_o = rd_q;
    assign wr_stb_o = wr_q;
    assign wr_data_o = wdat_q;
    assign crc_err_o = cerr_q;
endmodule

// File: testbench/fesel_host.sv
// Host controller model: drives the four-wire serial port of the status block.
// Assumes a five-cycle serial half period against the block clock.
`timescale 1ns/100ps

module fesel_host (
    // Clock
    input wire logic clk_i,
    // Serial pins
    output logic cs_n_o,
    output logic sclk_o,
    output logic mosi_o,
    input wire logic miso_i,
    // Read result, one-cycle pulse
    output logic done_o,
    output logic [15:0] word_o
);
    localparam int HALF = 5;

    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        mosi_o = 1'b0;
        done_o = 1'b0;
        word_o = 16'h0000;
    end

    function automatic logic [7:0] crc8(input logic [23:0] bits);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ bits[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction

    // Data set at the fall, read back just before the rise
    task automatic bit_x(input logic b, output logic s);
        @(negedge clk_i);
        sclk_o = 1'b0;
        mosi_o = b;
        repeat (HALF) @(negedge clk_i);
        s = miso_i;
        sclk_o = 1'b1;
        repeat (HALF) @(negedge clk_i);
    endtask

    task automatic frame(input logic [7:0] cmd, input logic [15:0] data,
                         input logic crc, input logic bad);
        logic [7:0] k;
        logic s;
        logic [15:0] r;
        k = crc8({cmd, data}) ^ {7'h00, bad};
        @(negedge clk_i);
        cs_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) bit_x(cmd[i], s);
        for (int i = 15; i >= 0; i--) begin
            bit_x(data[i], s);
            r[i] = s;
        end
        if (crc) for (int i = 7; i >= 0; i--) bit_x(k[i], s);
        @(negedge clk_i);
        cs_n_o = 1'b1;
        // Deselected line must not keep a stale level
        mosi_o = ~mosi_o;
        if (cmd[6]) begin
            word_o = r;
            done_o = 1'b1;
            @(negedge clk_i);
            done_o = 1'b0;
        end
        repeat (HALF) @(negedge clk_i);
    endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench for the front-end status block.
// Assumes the host model owns all serial pins; conditions change at falling edges.
`timescale 1ns/100ps

module tb;
    localparam logic [7:0] REV = 8'h3C; // Arbitrary value
    logic clk, rst, chan, tsd, thi, conv;
    logic cs_n, sclk, mosi, miso, miso_oe, err_n, err_oe;
    logic vmode, cur_off, fs_off, amp_off, done;
    logic [15:0] word;
    logic [15:0] expq[$];
    logic [15:0] cv[3] = '{16'h2000, 16'h6000, 16'h4000};
    int mismatches, checked;
    wire miso_w = miso_oe ? miso : 1'bz;

    fesel_top #(.REV_ID(REV)) dut (.REF_CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n),
        .SCLK_I(sclk), .MOSI_I(mosi), .MISO_O(miso), .MISO_OE_O(miso_oe),
        .CHAN_ERR_I(chan), .TEMP_SD_I(tsd), .TEMP_HI_I(thi), .CONV_CRC_EN_I(conv),
        .ERR_N_O(err_n), .ERR_N_OE_O(err_oe), .FORCE_VMODE_O(vmode),
        .CUR_SRC_OFF_O(cur_off), .FIELD_SUPPLY_OFF_O(fs_off), .AMP_PWRDN_O(amp_off));
    fesel_host host (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi),
        .miso_i(miso_w), .done_o(done), .word_o(word));

    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    function automatic logic [15:0] st(input logic [5:0] f);
        return {REV, 2'b00, f[5:2], 1'b0, f[0]};
    endfunction

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        expq.push_back(exp);
        host.frame({4'h4, a}, 16'h0000, 1'b0, 1'b0);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic crc, bad);
        host.frame({4'h0, a}, d, crc, bad);
    endtask

    task automatic pins(input logic e, input logic [3:0] p);
        repeat (3) @(negedge clk);
        check("err pin", {14'h0, err_n, err_oe}, {15'h0, e});
        check("power", {12'h0, vmode, cur_off, fs_off, amp_off}, {12'h0, p});
    endtask

    always @(posedge clk) begin
        if (done === 1'b1) begin
            check("read word", word, expq.size() ? expq.pop_front() : 16'hXXXX);
        end
    end

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        #400000;
        mismatches++;
        test_done();
    end

    initial begin
        logic [15:0] m;
        logic [2:0] c;
        mismatches = 0;
        checked = 0;
        rst = 1'b1;
        {chan, tsd, thi, conv} = 4'h0;
        void'($urandom(40177));
        repeat (4) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        pins(0, 4'h0);
        rd(4'h0, st(6'h00));
        wr(4'h0, 16'hFFFF, 0, 0);
        rd(4'h0, st(6'h00));
        rd(4'h9, 16'h0000);
        // One-cycle channel error
        chan = 1'b1;
        @(negedge clk) chan = 1'b0;
        pins(0, 4'h0);
        rd(4'h0, st(6'h20));
        rd(4'h0, st(6'h00));
        thi = 1'b1;
        pins(1, 4'h0);
        rd(4'h0, st(6'h05));
        rd(4'h0, st(6'h05));
        wr(4'h6, 16'h0004, 0, 0);
        pins(0, 4'h0);
        thi = 1'b0;
        rd(4'h0, st(6'h04));
        rd(4'h0, st(6'h00));
        tsd = 1'b1;
        pins(1, 4'hF);
        wr(4'h1, 16'h0200, 0, 0);
        rd(4'h1, 16'h0200);
        rd(4'h0, st(6'h09));
        tsd = 1'b0;
        pins(0, 4'hF);
        rd(4'h0, st(6'h08));
        pins(0, 4'h4);
        conv = 1'b1;
        wr(4'h1, 16'h4000, 0, 0);
        wr(4'h6, 16'h0010, 1, 1);
        rd(4'h6, 16'h0004);
        rd(4'h0, st(6'h11));
        rd(4'h0, st(6'h00));
        wr(4'h6, 16'h0010, 1, 0);
        rd(4'h6, 16'h0010);
        // Reserved patterns, then converter side off
        for (int i = 0; i < 3; i++) begin
            conv = (i < 2);
            wr(4'h1, cv[i], i == 0, 0);
            rd(4'h1, cv[i]);
            wr(4'h6, 16'(i * 4 + 32), 0, 0);
            rd(4'h6, 16'(i * 4 + 32));
        end
        wr(4'h1, 16'h0000, 0, 0);
        for (int i = 0; i < 8; i++) begin
            m = 16'($urandom() & 32'h3C);
            c = 3'($urandom());
            wr(4'h6, m, 0, 0);
            {chan, tsd, thi} = c;
            pins((c[2] & ~m[5]) | (c[1] & ~m[3]) | (c[0] & ~m[2]), {4{c[1]}});
            {chan, tsd, thi} = 3'h0;
            rd(4'h0, st({c[2], 1'b0, c[1], c[0], 2'b00}));
        end
        // Every flag masked: live conditions must not reach the pin
        wr(4'h6, 16'h003C, 0, 0);
        {chan, tsd, thi} = 3'h7;
        pins(0, 4'hF);
        {chan, tsd, thi} = 3'h0;
        rd(4'h0, st(6'h2C));
        test_done();
    end
endmodule
